// >>> logic/opmode_clock_ctrl.sv
// Behaviour
// - Run mode divides high clock 1..64
// - Slow mode uses low clock, high off
// - Halt without idle enters sleep
// - Voltage detector blocks deep sleep
// - Light sleep keeps substitute clock, watchdog clock only on substitute source
// - First_idle_state stops CPU and system oscillator
// - First_idle_state watchdog clock follows its source
// - Second_idle_state keeps system oscillator running
// - Divider field decodes low or ratios
// - High select bit picks undivided clock
// - High oscillator off on low source
// - Fast wake runs on substitute clock
// - Low ready flag timing after wake
// - High ready flag timing after wake
// - Deep sleep needs watchdog, detector off
// - Deep entry clears watchdog and timeout flag, sets power-down flag
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module opmode_clock_ctrl
  import opmode_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic              halt,
  input  wire logic              wake,
  input  wire logic              low_voltage_detect_enable,
  input  wire logic              wdt_enable,
  input  wire logic              wdt_src_sub,
  input  wire logic              system_clock_keep_on,
  input  wire logic              hs_is_crystal,
  input  wire logic              ls_is_crystal,
  input  wire logic              hs_tick,
  input  wire logic              ls_tick,
  output logic                   hs_osc_on,
  output logic                   ls_osc_on,
  output logic                   sys_clk_en,
  output logic                   cpu_clk_en,
  output logic                   substitute_clock_en,
  output logic                   watchdog_clock_en,
  output logic                   time_base_clock_en,
  output logic                   watchdog_disable,
  output logic                   watchdog_clear,
  output logic                   power_down_flag_set,
  output logic                   watchdog_timeout_flag_clear,
  output logic [2:0]             mode_state,
  output logic                   irq
);

  typedef struct packed {
    mode_t            st;
    logic [2:0]       cks;
    logic             fast_wake_enable;
    logic             idle_enable;
    logic             high_clock_select;
    logic             high_speed_ready_flag;
    logic             low_speed_ready_flag;
    logic [RDY_W-1:0] hs_cnt;
    logic [RDY_W-1:0] ls_cnt;
    logic             fw_active;
    logic [1:0]       wdt_div;
    logic [EV_W-1:0]  status;
    logic [EV_W-1:0]  mask;
    logic [7:0]       rdata;
    logic             wdt_clr;
    logic             pdf_set;
    logic             to_clr;
  } ctrl_state_t;

  ctrl_state_t s_r;
  ctrl_state_t s_nxt;

  logic            src_low;
  logic            div_tick;
  logic            sys_tick;
  logic            sys_div4;
  logic [EV_W-1:0] ev;
  logic [7:0]      smc_rd;
  logic            sleeping;

  // ****************************************
  // Clock selection
  // ****************************************
  assign src_low = src_is_low(s_r.high_clock_select, s_r.cks);

  ratio_divider #(
    .CNT_W (6)
  ) u_div (
    .core_clk (core_clk),
    .reset    (reset),
    .src_tick (hs_tick),
    .shift    (div_shift(s_r.high_clock_select, s_r.cks)),
    .div_tick (div_tick)
  );

  assign sleeping = (s_r.st == ST_DEEP) || (s_r.st == ST_LIGHT)
                    || (s_r.st == ST_FIRST_IDLE_STATE);

  always_comb begin
    if (src_low) begin
      sys_tick = ls_tick && s_r.low_speed_ready_flag;
    end else if (s_r.fw_active) begin
      sys_tick = ls_tick;
    end else begin
      sys_tick = div_tick && s_r.high_speed_ready_flag;
    end
  end

  assign sys_clk_en = sys_tick
                      && ((s_r.st == ST_RUN) || (s_r.st == ST_SECOND_IDLE_STATE));
  assign cpu_clk_en = sys_tick && (s_r.st == ST_RUN);
  assign sys_div4   = sys_clk_en && (s_r.wdt_div == 2'h3);

  // ****************************************
  // Oscillator and peripheral clocks
  // ****************************************
  assign hs_osc_on = !src_low && ((s_r.st == ST_RUN) || (s_r.st == ST_SECOND_IDLE_STATE));
  assign ls_osc_on = (s_r.st != ST_DEEP);
  assign substitute_clock_en = ls_tick && ls_osc_on;
  assign watchdog_clock_en = (s_r.st != ST_DEEP)
                             && (wdt_src_sub ? substitute_clock_en
                                             : sys_div4);
  assign time_base_clock_en = ls_tick && (s_r.st != ST_DEEP)
                              && (s_r.st != ST_LIGHT);
  assign watchdog_disable = (s_r.st == ST_DEEP);
  assign watchdog_clear = s_r.wdt_clr;
  assign power_down_flag_set = s_r.pdf_set;
  assign watchdog_timeout_flag_clear = s_r.to_clr;
  assign mode_state = s_r.st;
  assign rdata = s_r.rdata;
  assign irq = |(s_r.status & s_r.mask);

  assign smc_rd = {s_r.cks, s_r.fast_wake_enable, s_r.low_speed_ready_flag, s_r.high_speed_ready_flag,
                   s_r.idle_enable, s_r.high_clock_select};

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    ev = '0;
    s_nxt.wdt_clr = 1'b0;
    s_nxt.pdf_set = 1'b0;
    s_nxt.to_clr  = 1'b0;
    if (sys_clk_en) begin
      s_nxt.wdt_div = s_r.wdt_div + 1'b1;
    end
    case (s_r.st)
      ST_RUN: begin
        if (halt) begin
          ev[EV_SLEEP] = 1'b1;
          if (s_r.idle_enable) begin
            s_nxt.st = system_clock_keep_on ? ST_SECOND_IDLE_STATE : ST_FIRST_IDLE_STATE;
          end else if (!low_voltage_detect_enable && !wdt_enable) begin
            s_nxt.st = ST_DEEP;
            s_nxt.wdt_clr = 1'b1;
            s_nxt.pdf_set = 1'b1;
            s_nxt.to_clr  = 1'b1;
          end else begin
            s_nxt.st = ST_LIGHT;
          end
        end
      end
      ST_DEEP, ST_LIGHT, ST_FIRST_IDLE_STATE, ST_SECOND_IDLE_STATE: begin
        if (wake) begin
          ev[EV_WAKE] = 1'b1;
          s_nxt.st = ST_RUN;
          s_nxt.fw_active = s_r.fast_wake_enable && hs_is_crystal
                            && !src_low && (s_r.st != ST_DEEP)
                            && (s_r.st != ST_SECOND_IDLE_STATE);
        end
      end
      default: begin
        s_nxt.st = ST_RUN;
      end
    endcase
    // High-speed ready counter
    if (!hs_osc_on
        || ((s_nxt.st != ST_RUN) && (s_nxt.st != ST_SECOND_IDLE_STATE))) begin
      s_nxt.high_speed_ready_flag = 1'b0;
      s_nxt.hs_cnt = '0;
    end else if (hs_tick && !s_r.high_speed_ready_flag) begin
      s_nxt.hs_cnt = s_r.hs_cnt + 1'b1;
      if (s_nxt.hs_cnt >= (hs_is_crystal ? HXT_READY : HRC_READY)) begin
        s_nxt.high_speed_ready_flag = 1'b1;
        ev[EV_HRDY] = 1'b1;
      end
    end
    if (s_r.high_speed_ready_flag) begin
      s_nxt.fw_active = 1'b0;
    end
    // Low-speed ready counter
    if (!ls_osc_on || (s_nxt.st == ST_DEEP)) begin
      s_nxt.low_speed_ready_flag = 1'b0;
      s_nxt.ls_cnt = '0;
    end else if (ls_tick && !s_r.low_speed_ready_flag) begin
      s_nxt.ls_cnt = s_r.ls_cnt + 1'b1;
      if (s_nxt.ls_cnt >= (ls_is_crystal ? LXT_READY : LRC_READY)) begin
        s_nxt.low_speed_ready_flag = 1'b1;
        ev[EV_LRDY] = 1'b1;
      end
    end
    // Register port
    s_nxt.rdata = '0;
    if (wr_en) begin
      case (addr)
        ADDR_SMC: begin
          s_nxt.cks = wdata[CKS_LSB +: 3];
          s_nxt.fast_wake_enable = wdata[BIT_FST];
          s_nxt.idle_enable = wdata[BIT_IDLE];
          s_nxt.high_clock_select = wdata[BIT_HL];
        end
        ADDR_MASK: begin
          s_nxt.mask = wdata[EV_W-1:0];
        end
        default: begin
        end
      endcase
    end
    if (rd_en) begin
      case (addr)
        ADDR_SMC: begin
          s_nxt.rdata = smc_rd;
        end
        ADDR_STAT: begin
          s_nxt.rdata = {{(DATA_W-EV_W){1'b0}}, s_r.status};
          s_nxt.status = '0;
        end
        ADDR_MASK: begin
          s_nxt.rdata = {{(DATA_W-EV_W){1'b0}}, s_r.mask};
        end
        default: begin
        end
      endcase
    end
    s_nxt.status = s_nxt.status | ev;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_r <= '0;
      s_r.st <= ST_RUN;
      s_r.cks <= SMC_RESET[CKS_LSB +: 3];
      s_r.fast_wake_enable <= SMC_RESET[BIT_FST];
      s_r.idle_enable <= SMC_RESET[BIT_IDLE];
      s_r.high_clock_select <= SMC_RESET[BIT_HL];
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  logic full_sel;
  assign full_sel = (s_r.st == ST_RUN) && s_r.high_clock_select
                    && s_r.high_speed_ready_flag && !s_r.fw_active;

  deep_blocked_a: assert property (
    (s_r.st == ST_RUN) && halt && low_voltage_detect_enable
    |=> s_r.st != ST_DEEP) else $error("deep sleep with detector on");
  deep_wdt_a: assert property (
    (s_r.st == ST_RUN) && halt && wdt_enable |=> s_r.st != ST_DEEP)
    else $error("deep sleep with watchdog on");
  deep_clocks_a: assert property (
    s_r.st == ST_DEEP |-> !cpu_clk_en && !substitute_clock_en
    && !watchdog_clock_en && watchdog_disable)
    else $error("clock running in deep sleep");
  light_keep_a: assert property (
    s_r.st == ST_LIGHT |-> !cpu_clk_en && (substitute_clock_en == ls_tick))
    else $error("light sleep clocks wrong");
  first_idle_state_stop_a: assert property (
    s_r.st == ST_FIRST_IDLE_STATE |-> !hs_osc_on && !sys_clk_en)
    else $error("first_idle_state oscillator running");
  first_idle_state_wdt_a: assert property (
    s_r.st == ST_FIRST_IDLE_STATE && !wdt_src_sub |-> !watchdog_clock_en)
    else $error("first_idle_state watchdog clock on");
  second_idle_state_keep_a: assert property (
    s_r.st == ST_SECOND_IDLE_STATE |-> !cpu_clk_en && (hs_osc_on == !src_low))
    else $error("second_idle_state oscillator wrong");
  slow_hs_off_a: assert property (
    src_low |-> !hs_osc_on) else $error("high oscillator on in slow");
  full_rate_a: assert property (
    full_sel ##1 hs_tick && full_sel ##1 full_sel |-> sys_clk_en)
    else $error("undivided clock missing");
  ratio_gap_a: assert property (
    sys_clk_en && !src_low && !s_r.high_clock_select && !s_r.fw_active
    |=> !sys_clk_en) else $error("divided clock too fast");
  hto_low_a: assert property (
    sleeping |-> !s_r.high_speed_ready_flag) else $error("high ready set while stopped");
  lto_low_a: assert property (
    s_r.st == ST_DEEP |-> !s_r.low_speed_ready_flag) else $error("low ready set in deep");
  fast_wake_a: assert property (
    (s_r.st == ST_RUN) && s_r.fw_active && !src_low && ls_tick
    |-> cpu_clk_en) else $error("fast wake clock missing");
  deep_entry_a: assert property (
    (s_r.st != ST_DEEP) ##1 (s_r.st == ST_DEEP)
    |-> watchdog_clear && power_down_flag_set
    && watchdog_timeout_flag_clear) else $error("deep entry flags missing");

  deep_seen_c: cover property (s_r.st == ST_DEEP ##[1:50] s_r.st == ST_RUN);
  second_idle_state_seen_c: cover property (s_r.st == ST_SECOND_IDLE_STATE);
  fast_wake_c: cover property (s_r.fw_active ##[1:1000] s_r.high_speed_ready_flag);
  light_seen_c: cover property (s_r.st == ST_LIGHT && watchdog_clock_en);

endmodule // opmode_clock_ctrl
`default_nettype wire

// >>> logic/opmode_pkg.sv
`default_nettype none
package opmode_pkg;

  // ****************************************
  // Register map and fields
  // ****************************************
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned ADDR_W   = 2;
  localparam logic [1:0]  ADDR_SMC  = 2'h0;
  localparam logic [1:0]  ADDR_STAT = 2'h1;
  localparam logic [1:0]  ADDR_MASK = 2'h2;
  localparam int unsigned BIT_HL   = 0;
  localparam int unsigned BIT_IDLE = 1;
  localparam int unsigned BIT_HTO  = 2;
  localparam int unsigned BIT_LTO  = 3;
  localparam int unsigned BIT_FST  = 4;
  localparam int unsigned CKS_LSB  = 5;
  localparam logic [7:0]  SMC_RESET = 8'h03;

  // ****************************************
  // Interrupt events
  // ****************************************
  localparam int unsigned EV_W     = 4;
  localparam int unsigned EV_SLEEP = 0;
  localparam int unsigned EV_WAKE  = 1;
  localparam int unsigned EV_HRDY  = 2;
  localparam int unsigned EV_LRDY  = 3;

  // ****************************************
  // Oscillator settle counts, oscillator cycles
  // ****************************************
  localparam int unsigned RDY_W     = 11;
  localparam logic [10:0] HXT_READY = 11'h400;
  localparam logic [10:0] HRC_READY = 11'h010;
  localparam logic [10:0] LXT_READY = 11'h400;
  localparam logic [10:0] LRC_READY = 11'h002;

  // ****************************************
  // Clock selection
  // ****************************************
  localparam logic [2:0] CKS_FIRST_HS = 3'h2;
  localparam logic [3:0] CKS_DIV_BASE = 4'h8;
  localparam logic [2:0] SHIFT_FULL   = 3'h0;

  typedef enum logic [2:0] {
    ST_RUN, ST_DEEP, ST_LIGHT, ST_FIRST_IDLE_STATE, ST_SECOND_IDLE_STATE
  } mode_t;

  // Log2 of the divide ratio
  function automatic logic [2:0] div_shift(input logic       hl,
                                           input logic [2:0] cks);
    div_shift = hl ? SHIFT_FULL : 3'(CKS_DIV_BASE - {1'b0, cks});
  endfunction

  // Low-speed clock chosen
  function automatic logic src_is_low(input logic       hl,
                                      input logic [2:0] cks);
    src_is_low = !hl && (cks < CKS_FIRST_HS);
  endfunction

endpackage
`default_nettype wire

// >>> logic/ratio_divider.sv
`timescale 1ns/1ps
`default_nettype none
module ratio_divider
  import opmode_pkg::*;
#(
  parameter int unsigned CNT_W = 6
) (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       src_tick,
  input  wire logic [2:0] shift,
  output logic            div_tick
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [2:0]       shift;
    logic             tick;
  } div_state_t;

  div_state_t s_r;
  div_state_t s_nxt;
  logic [CNT_W-1:0] mask;

  // ****************************************
  // Whole-pulse divider
  // ****************************************
  always_comb begin
    mask  = CNT_W'((1 << s_r.shift) - 1);
    s_nxt = s_r;
    s_nxt.tick  = 1'b0;
    s_nxt.shift = shift;
    if (shift != s_r.shift) begin
      s_nxt.cnt = '0;
    end else if (src_tick) begin
      if ((s_r.cnt & mask) == mask) begin
        s_nxt.tick = 1'b1;
        s_nxt.cnt  = '0;
      end else begin
        s_nxt.cnt = s_r.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign div_tick = s_r.tick;

endmodule // ratio_divider
`default_nettype wire

// >>> tb/operating_mode_clock_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module operating_mode_clock_control_test;
  import opmode_pkg::*;
  logic core_clk = 0, reset = 1, wr_en = 0, rd_en = 0, halt = 0, wake = 0;
  logic lvd = 0, wdt_en = 1, wsub = 0, keep = 0, hs_xt = 1, ls_xt = 0;
  logic [1:0] addr = 0;
  logic [7:0] wdata = 0, rdata, d;
  logic hs_tick, ls_tick, hs_on, ls_on, sys_en, cpu_en, sub_en, wdc_en;
  logic tbc_en, wd_dis, wd_clr, pdf_set, to_clr, irq;
  logic [2:0] mode;
  int fails = 0, check_count = 0, cyc = 0, cs, cc, csub, cw, ct, t0, i, k;

  // ****************************************
  // Design, oscillators, clock
  // ****************************************
  opmode_clock_ctrl i_dut (
    .core_clk(core_clk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .halt(halt), .wake(wake),
    .low_voltage_detect_enable(lvd), .wdt_enable(wdt_en),
    .wdt_src_sub(wsub), .system_clock_keep_on(keep),
    .hs_is_crystal(hs_xt), .ls_is_crystal(ls_xt), .hs_tick(hs_tick),
    .ls_tick(ls_tick), .hs_osc_on(hs_on), .ls_osc_on(ls_on),
    .sys_clk_en(sys_en), .cpu_clk_en(cpu_en), .substitute_clock_en(sub_en),
    .watchdog_clock_en(wdc_en), .time_base_clock_en(tbc_en),
    .watchdog_disable(wd_dis), .watchdog_clear(wd_clr),
    .power_down_flag_set(pdf_set), .watchdog_timeout_flag_clear(to_clr),
    .mode_state(mode), .irq(irq));

  osc_model i_osc (.core_clk(core_clk), .reset(reset), .hs_osc_on(hs_on),
    .ls_osc_on(ls_on), .hs_tick(hs_tick), .ls_tick(ls_tick));

  always #2 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cyc++;
    cs += (sys_en === 1'b1);
    cc += (cpu_en === 1'b1);
    csub += (sub_en === 1'b1);
    cw += (wdc_en === 1'b1);
    ct += (tbc_en === 1'b1);
    if (cyc == 40000) begin
      fails++;
      final_report();
    end
  end

  // ****************************************
  // Bus, mode and counting tasks
  // ****************************************
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge core_clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic pulse_hw(input logic h, input logic [2:0] m);
    @(posedge core_clk);
    halt <= h;
    wake <= !h;
    @(posedge core_clk);
    halt <= 1'b0;
    wake <= 1'b0;
    #1 `CHK(mode, m)
  endtask

  task automatic win(input int n);
    @(posedge core_clk);
    #1 {cs, cc, csub, cw, ct} = '0;
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wait_hrdy;
    int n;
    n = 0;
    d = '0;
    while (d[BIT_HTO] !== 1'b1 && n < 1500) begin
      rd(ADDR_SMC);
      n++;
    end
  endtask

  task automatic cfg(input logic l, input logic w, input logic s,
                     input logic kp);
    @(posedge core_clk);
    lvd <= l;
    wdt_en <= w;
    wsub <= s;
    keep <= kp;
  endtask

  function automatic logic near(input int v, input int e);
    return v >= e - 1 && v <= e + 1;
  endfunction

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    t0 = cyc;
    rd(ADDR_SMC);
    `CHK(d, SMC_RESET)
    for (i = 1; i < 4; i++) begin
      rd(2'(i));
      `CHK(d, 8'h00)
    end
    wait_hrdy();
    `CHK(cyc - t0 >= 1024 && cyc - t0 <= 1040, 1'b1)
    wr(ADDR_SMC, 8'h03);
    rd(ADDR_SMC);
    `CHK(d, 8'h0f)
    $display("test reset_regs done");

    for (i = 1; i < 8; i++) begin
      wr(ADDR_SMC, (i == 1) ? 8'h03 : {3'(i), 5'h02});
      win(512);
      k = (i == 1) ? 512 : 512 >> (8 - i);
      `CHK(near(cs, k), 1'b1)
      `CHK(near(cc, k), 1'b1)
      `CHK(near(cw, k / 4), 1'b1)
    end
    `CHK(near(ct, 64), 1'b1)
    for (i = 0; i < 2; i++) begin
      wr(ADDR_SMC, {3'(i), 5'h02});
      win(512);
      `CHK(hs_on, 1'b0)
      `CHK(near(cs, 64), 1'b1)
    end
    wr(ADDR_SMC, 8'h03);
    wait_hrdy();
    $display("test clock_select done");

    cfg(1'b0, 1'b0, 1'b0, 1'b0);
    wr(ADDR_MASK, 8'h01);
    wr(ADDR_SMC, 8'h01);
    pulse_hw(1'b1, 3'(ST_DEEP));
    `CHK({wd_clr, pdf_set, to_clr, wd_dis, irq}, 5'h1f)
    `CHK({hs_on, ls_on}, 2'b00)
    win(128);
    `CHK(cs + cc + csub + cw + ct, 0)
    `CHK(wd_clr, 1'b0)
    rd(ADDR_SMC);
    `CHK(d[3:2], 2'b00)
    rd(ADDR_STAT);
    `CHK({d[EV_SLEEP], irq}, 2'b10)
    pulse_hw(1'b0, 3'(ST_RUN));
    wr(ADDR_MASK, 8'h00);
    wait_hrdy();
    rd(ADDR_SMC);
    `CHK(d[BIT_LTO], 1'b1)
    $display("test deep_sleep done");

    for (k = 0; k < 2; k++) begin
      cfg(k == 0, k == 1, k == 1, 1'b0);
      pulse_hw(1'b1, 3'(ST_LIGHT));
      win(128);
      `CHK(near(csub, 16), 1'b1)
      `CHK(cc, 0)
      `CHK((k == 1) ? near(cw, 16) : (cw == 0), 1'b1)
      pulse_hw(1'b0, 3'(ST_RUN));
      wait_hrdy();
    end
    cfg(1'b0, 1'b1, 1'b0, 1'b0);
    $display("test light_sleep done");

    cfg(1'b0, 1'b1, 1'b0, 1'b1);
    wr(ADDR_SMC, 8'h03);
    pulse_hw(1'b1, 3'(ST_SECOND_IDLE_STATE));
    win(128);
    `CHK(near(cs, 128), 1'b1)
    `CHK(near(cw, 32), 1'b1)
    `CHK(cc, 0)
    pulse_hw(1'b0, 3'(ST_RUN));
    cfg(1'b0, 1'b1, 1'b0, 1'b0);
    $display("test second_idle_state done");

    for (k = 0; k < 2; k++) begin
      cfg(1'b0, 1'b1, k == 1, 1'b0);
      wr(ADDR_SMC, (k == 1) ? 8'h13 : 8'h03);
      pulse_hw(1'b1, 3'(ST_FIRST_IDLE_STATE));
      win(128);
      `CHK(cs + cc, 0)
      `CHK((k == 1) ? near(cw, 16) : (cw == 0), 1'b1)
      `CHK(hs_on, 1'b0)
      rd(ADDR_SMC);
      `CHK(d[BIT_HTO], 1'b0)
      pulse_hw(1'b0, 3'(ST_RUN));
      win(200);
      `CHK(cs > 0, k == 1)
      wait_hrdy();
    end
    $display("test first_idle_state_fast_wake done");
    @(posedge core_clk);
    hs_xt <= 1'b0;
    ls_xt <= 1'b1;
    cfg(1'b0, 1'b0, 1'b0, 1'b0);
    wr(ADDR_SMC, 8'h01);
    pulse_hw(1'b1, 3'(ST_DEEP));
    pulse_hw(1'b0, 3'(ST_RUN));
    t0 = cyc;
    wait_hrdy();
    `CHK(cyc - t0 >= 16 && cyc - t0 <= 24, 1'b1)
    for (i = 0; i < 5000 && d[BIT_LTO] !== 1'b1; i++) begin
      rd(ADDR_SMC);
    end
    `CHK(cyc - t0 >= 8192 && cyc - t0 <= 8210, 1'b1)
    $display("test rc_crystal done");
    final_report();
  end
endmodule // operating_mode_clock_control_test
`default_nettype wire

// >>> tb/osc_model.sv
`timescale 1ns/1ps
`default_nettype none
module osc_model #(
  parameter int unsigned HS_DIV = 1,
  parameter int unsigned LS_DIV = 8
) (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic hs_osc_on,
  input  wire logic ls_osc_on,
  output logic      hs_tick,
  output logic      ls_tick
);
  // ****************************************
  // Oscillator cycles as enable pulses
  // ****************************************
  int unsigned hs_cnt;
  int unsigned ls_cnt;

  // A stopped oscillator gives no ticks
  always_ff @(posedge core_clk) begin
    if (reset || !hs_osc_on) begin
      hs_cnt  <= 0;
      hs_tick <= 1'b0;
    end else begin
      hs_cnt  <= (hs_cnt + 1 >= HS_DIV) ? 0 : hs_cnt + 1;
      hs_tick <= (hs_cnt + 1 >= HS_DIV);
    end
    if (reset || !ls_osc_on) begin
      ls_cnt  <= 0;
      ls_tick <= 1'b0;
    end else begin
      ls_cnt  <= (ls_cnt + 1 >= LS_DIV) ? 0 : ls_cnt + 1;
      ls_tick <= (ls_cnt + 1 >= LS_DIV);
    end
  end
endmodule // osc_model
`default_nettype wire
